// file: hw/acc_defs.svh
// register offsets, field positions, reset values and timing counts
`ifndef ACC_DEFS_SVH
`define ACC_DEFS_SVH
`define ACC_ADDR_RUN 8'h61
`define ACC_ADDR_MODE 8'h62
`define ACC_ADDR_OFFSET_REFERENCE_SELECT 8'h65
`define ACC_ADDR_LINK 8'h70
`define ACC_ADDR_STAT 8'h71
`define ACC_RST_RUN 8'h01
`define ACC_RST_MODE 8'h01
`define ACC_RST_OFFSET_REFERENCE_SELECT 8'h01
`define ACC_RST_LINK 8'h00
`define ACC_BIT_RUN 0
`define ACC_BIT_FG 0
`define ACC_BIT_BG 1
`define ACC_BIT_FGOS 2
`define ACC_BIT_BGOS 3
`define ACC_BIT_OFFSET_REFERENCE_SELECT 2
`define ACC_BIT_LINK 0
`define ACC_BIT_FGDONE 0
`define ACC_BIT_BGRUN 1
`define ACC_BIT_SEQERR 2
`define ACC_CLEAR_NS 64
`define ACC_CLK_NS 8
`define ACC_CLEAR_CYC ((`ACC_CLEAR_NS + `ACC_CLK_NS - 1) / `ACC_CLK_NS)
`define ACC_FG_CYC 16'd1000
`endif

// file: hw/acc_pkg.sv
// types shared by the calibration control block
package acc_pkg;
  typedef enum logic [4:0] {
    ACC_HOLD = 5'b00001,
    ACC_CLEAR = 5'b00010,
    ACC_FG = 5'b00100,
    ACC_FGOS = 5'b01000,
    ACC_BG = 5'b10000
  } acc_state_t;
endpackage

// file: hw/acc_divider.sv
// clock enable divider held in reset while calibration is stopped
`timescale 1ns/1ns
module acc_divider #(
  parameter int DIV_W = 4
) (
  input wire logic ref_clk_in,
  input wire logic rst_n_in,
  input wire logic div_clear_in,
  input wire logic [DIV_W-1:0] div_ratio_in,
  output logic tick_out
);
  logic [DIV_W-1:0] cnt_q;

  always_ff @(posedge ref_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      cnt_q <= '0;
      tick_out <= 1'b0;
    end
    else if (div_clear_in)
    begin
      cnt_q <= '0;
      tick_out <= 1'b0;
    end
    else if (cnt_q >= div_ratio_in)
    begin
      cnt_q <= '0;
      tick_out <= 1'b1;
    end
    else
    begin
      cnt_q <= cnt_q + 1'b1;
      tick_out <= 1'b0;
    end
  end
endmodule

// file: hw/acc_top.sv
// calibration control register bank and calibration sequencer
//
// Chosen here: the plain strobed port.
`timescale 1ns/1ns
`include "acc_defs.svh"
module acc_top #(
  parameter int DIV_W = 4,
  parameter logic [15:0] FG_CYC = `ACC_FG_CYC
) (
  input wire logic ref_clk_in,
  input wire logic arst_n_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [DIV_W-1:0] dig_ratio_in,
  input wire logic [DIV_W-1:0] link_ratio_in,
  output logic [7:0] reg_rdata_out,
  output logic cal_reset_out,
  output logic cal_clear_out,
  output logic fg_tuning_out,
  output logic fg_offset_out,
  output logic bg_tuning_out,
  output logic bg_offset_out,
  output logic offset_reference_select_spare_out,
  output logic foreground_complete_flag_out,
  output logic serial_link_enable_out,
  output logic dig_tick_out,
  output logic link_tick_out
);
  localparam logic [7:0] CLEAR_CYC = 8'(`ACC_CLEAR_CYC);

  logic rst_s1_q;
  logic rst_s2_q;
  logic rst_n;
  logic [7:0] run_q;
  logic [7:0] mode_q;
  logic [7:0] offset_reference_select_q;
  logic [7:0] link_q;
  logic run_prev_q;
  logic [3:0] cap_mode_q;
  logic cap_offset_reference_select_q;
  logic seq_err_q;
  acc_pkg::acc_state_t state_q;
  acc_pkg::acc_state_t state_d;
  logic [15:0] cnt_q;
  logic run_on;
  logic run_rise;
  logic div_clear;
  logic dig_tick;
  logic link_tick;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
    hit = (a == o);
  endfunction

  function automatic logic in_state(input acc_pkg::acc_state_t s,
                                    input acc_pkg::acc_state_t t);
    in_state = (s == t);
  endfunction

  // reset release through two stages
  always_ff @(posedge ref_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      rst_s1_q <= 1'b0;
      rst_s2_q <= 1'b0;
    end
    else
    begin
      rst_s1_q <= 1'b1;
      rst_s2_q <= rst_s1_q;
    end
  end
  assign rst_n = rst_s2_q;

  assign run_on = run_q[`ACC_BIT_RUN];
  assign run_rise = run_on && !run_prev_q;
  assign div_clear = !run_on;

  // run control register
  always_ff @(posedge ref_clk_in or negedge rst_n)
  begin
    if (!rst_n)
      run_q <= `ACC_RST_RUN;
    else if (reg_wr_in && hit(reg_addr_in, `ACC_ADDR_RUN))
      run_q <= reg_wdata_in;
  end

  // calibration mode register
  always_ff @(posedge ref_clk_in or negedge rst_n)
  begin
    if (!rst_n)
      mode_q <= `ACC_RST_MODE;
    else if (reg_wr_in && hit(reg_addr_in, `ACC_ADDR_MODE))
      mode_q <= reg_wdata_in;
  end

  // offset reference register
  always_ff @(posedge ref_clk_in or negedge rst_n)
  begin
    if (!rst_n)
      offset_reference_select_q <= `ACC_RST_OFFSET_REFERENCE_SELECT;
    else if (reg_wr_in && hit(reg_addr_in, `ACC_ADDR_OFFSET_REFERENCE_SELECT))
      offset_reference_select_q <= reg_wdata_in;
  end

  // serial link control register
  always_ff @(posedge ref_clk_in or negedge rst_n)
  begin
    if (!rst_n)
      link_q <= `ACC_RST_LINK;
    else if (reg_wr_in && hit(reg_addr_in, `ACC_ADDR_LINK))
      link_q <= reg_wdata_in;
  end

  // sticky flag for link enabled while run control low
  always_ff @(posedge ref_clk_in or negedge rst_n)
  begin
    if (!rst_n)
      seq_err_q <= 1'b0;
    else if (link_q[`ACC_BIT_LINK] && !run_on)
      seq_err_q <= 1'b1;
    else if (reg_wr_in && hit(reg_addr_in, `ACC_ADDR_STAT)
             && reg_wdata_in[`ACC_BIT_SEQERR])
      seq_err_q <= 1'b0;
  end

  // previous run level; resets low so a pass starts after reset
  always_ff @(posedge ref_clk_in or negedge rst_n)
  begin
    if (!rst_n)
      run_prev_q <= 1'b0;
    else
      run_prev_q <= run_on;
  end

  // capture settings at run start
  always_ff @(posedge ref_clk_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cap_mode_q <= 4'h0;
      cap_offset_reference_select_q <= 1'b0;
    end
    else if (run_rise)
    begin
      cap_mode_q <= mode_q[3:0];
      cap_offset_reference_select_q <= offset_reference_select_q[`ACC_BIT_OFFSET_REFERENCE_SELECT];
    end
  end

  // sequencer next state
  always_comb
  begin
    state_d = state_q;
    case (state_q)
      acc_pkg::ACC_HOLD:
        if (run_rise)
          state_d = acc_pkg::ACC_CLEAR;
      acc_pkg::ACC_CLEAR:
        if (cnt_q == CLEAR_CYC - 8'h01)
        begin
          if (cap_mode_q[`ACC_BIT_FG])
            state_d = acc_pkg::ACC_FG;
          else
            state_d = acc_pkg::ACC_BG;
        end
      acc_pkg::ACC_FG:
        if (cnt_q == FG_CYC - 16'h0001)
        begin
          if (cap_mode_q[`ACC_BIT_FGOS])
            state_d = acc_pkg::ACC_FGOS;
          else
            state_d = acc_pkg::ACC_BG;
        end
      acc_pkg::ACC_FGOS:
        if (cnt_q == FG_CYC - 16'h0001)
          state_d = acc_pkg::ACC_BG;
      acc_pkg::ACC_BG:
        state_d = acc_pkg::ACC_BG;
      default:
        state_d = acc_pkg::ACC_HOLD;
    endcase
    if (!run_on)
      state_d = acc_pkg::ACC_HOLD;
  end

  always_ff @(posedge ref_clk_in or negedge rst_n)
  begin
    if (!rst_n)
      state_q <= acc_pkg::ACC_HOLD;
    else
      state_q <= state_d;
  end

  always_ff @(posedge ref_clk_in or negedge rst_n)
  begin
    if (!rst_n)
      cnt_q <= 16'h0000;
    else if (state_d != state_q)
      cnt_q <= 16'h0000;
    else
      cnt_q <= cnt_q + 16'h0001;
  end

  // hold and clear phase indications
  always_ff @(posedge ref_clk_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cal_reset_out <= 1'b1;
      cal_clear_out <= 1'b0;
    end
    else
    begin
      cal_reset_out <= in_state(state_d, acc_pkg::ACC_HOLD);
      cal_clear_out <= in_state(state_d, acc_pkg::ACC_CLEAR);
    end
  end

  // foreground phase indications
  always_ff @(posedge ref_clk_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      fg_tuning_out <= 1'b0;
      fg_offset_out <= 1'b0;
    end
    else
    begin
      fg_tuning_out <= in_state(state_d, acc_pkg::ACC_FG);
      fg_offset_out <= in_state(state_d, acc_pkg::ACC_FGOS) &&
                       cap_mode_q[`ACC_BIT_FG];
    end
  end

  // background phase and foreground complete flag
  always_ff @(posedge ref_clk_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      bg_tuning_out <= 1'b0;
      bg_offset_out <= 1'b0;
      foreground_complete_flag_out <= 1'b0;
    end
    else
    begin
      bg_tuning_out <= in_state(state_d, acc_pkg::ACC_BG) &&
                       cap_mode_q[`ACC_BIT_BG];
      bg_offset_out <= in_state(state_d, acc_pkg::ACC_BG) &&
                       cap_mode_q[`ACC_BIT_BG] &&
                       cap_mode_q[`ACC_BIT_BGOS];
      foreground_complete_flag_out <=
        in_state(state_d, acc_pkg::ACC_BG);
    end
  end

  // zero selects mid-code target, one the spare converter
  always_ff @(posedge ref_clk_in or negedge rst_n)
  begin
    if (!rst_n)
      offset_reference_select_spare_out <= 1'b0;
    else if (run_rise)
      offset_reference_select_spare_out <= offset_reference_select_q[`ACC_BIT_OFFSET_REFERENCE_SELECT];
    else
      offset_reference_select_spare_out <= cap_offset_reference_select_q;
  end

  // link enable forced low while calibration is stopped
  always_ff @(posedge ref_clk_in or negedge rst_n)
  begin
    if (!rst_n)
      serial_link_enable_out <= 1'b0;
    else
      serial_link_enable_out <= link_q[`ACC_BIT_LINK] && run_on;
  end

  // gated so no tick leaks out in the cycle run drops
  always_ff @(posedge ref_clk_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      dig_tick_out <= 1'b0;
      link_tick_out <= 1'b0;
    end
    else
    begin
      dig_tick_out <= dig_tick && run_on;
      link_tick_out <= link_tick && run_on;
    end
  end

  // read data one cycle after strobe
  always_ff @(posedge ref_clk_in or negedge rst_n)
  begin
    if (!rst_n)
      reg_rdata_out <= 8'h00;
    else if (!reg_rd_in)
      reg_rdata_out <= 8'h00;
    else if (hit(reg_addr_in, `ACC_ADDR_RUN))
      reg_rdata_out <= run_q;
    else if (hit(reg_addr_in, `ACC_ADDR_MODE))
      reg_rdata_out <= mode_q;
    else if (hit(reg_addr_in, `ACC_ADDR_OFFSET_REFERENCE_SELECT))
      reg_rdata_out <= offset_reference_select_q;
    else if (hit(reg_addr_in, `ACC_ADDR_LINK))
      reg_rdata_out <= link_q;
    else if (hit(reg_addr_in, `ACC_ADDR_STAT))
      reg_rdata_out <= {5'h00, seq_err_q, bg_tuning_out,
                        foreground_complete_flag_out};
    else
      reg_rdata_out <= 8'h00;
  end

  acc_divider #(.DIV_W(DIV_W)) u_dig_div (
    .ref_clk_in(ref_clk_in),
    .rst_n_in(rst_n),
    .div_clear_in(div_clear),
    .div_ratio_in(dig_ratio_in),
    .tick_out(dig_tick)
  );

  acc_divider #(.DIV_W(DIV_W)) u_link_div (
    .ref_clk_in(ref_clk_in),
    .rst_n_in(rst_n),
    .div_clear_in(div_clear),
    .div_ratio_in(link_ratio_in),
    .tick_out(link_tick)
  );
endmodule

// file: sim/acc_top_monitor.sv
// assertion checker for the calibration control block
`timescale 1ns/1ns
module acc_top_monitor #(
  parameter logic [15:0] FG_CYC = 16'd1000
) (
  input wire logic ref_clk_in,
  input wire logic arst_n_in,
  input wire logic cal_reset_out,
  input wire logic cal_clear_out,
  input wire logic fg_tuning_out,
  input wire logic fg_offset_out,
  input wire logic bg_tuning_out,
  input wire logic bg_offset_out,
  input wire logic offset_reference_select_spare_out,
  input wire logic foreground_complete_flag_out,
  input wire logic serial_link_enable_out,
  input wire logic dig_tick_out,
  input wire logic link_tick_out
);
  logic [15:0] fg_cnt_q;
  // length of the current foreground phase
  always_ff @(posedge ref_clk_in or negedge arst_n_in)
    if (!arst_n_in)
      fg_cnt_q <= 16'h0000;
    else
      fg_cnt_q <= fg_tuning_out ? fg_cnt_q + 16'h0001 : 16'h0000;
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!arst_n_in);
  sequence s_clear;
    cal_clear_out [*8] ##1 !cal_clear_out;
  endsequence
  sequence s_fg_end;
    $fell(fg_tuning_out) && !cal_reset_out;
  endsequence
  AST_HOLD_IDLE:
    assert property (cal_reset_out |-> !(cal_clear_out || fg_tuning_out ||
      fg_offset_out || bg_tuning_out || foreground_complete_flag_out ||
      serial_link_enable_out)) else $error("active while held");
  AST_DIV_STOP:
    assert property (cal_reset_out |-> !dig_tick_out && !link_tick_out)
    else $error("divider tick while held");
  AST_PASS_START:
    assert property ($fell(cal_reset_out) |-> cal_clear_out)
    else $error("pass did not begin with clear");
  AST_CLEAR_LEN:
    assert property ($rose(cal_clear_out) |-> s_clear)
    else $error("clear phase length");
  AST_FG_LEN:
    assert property (s_fg_end |-> fg_cnt_q == FG_CYC)
    else $error("foreground phase length");
  AST_FG_NEXT:
    assert property (s_fg_end |-> fg_offset_out ||
      foreground_complete_flag_out) else $error("after foreground");
  AST_FLAG_CAUSE:
    assert property ($rose(foreground_complete_flag_out) |->
      $past(cal_clear_out) || $past(fg_tuning_out) || $past(fg_offset_out))
    else $error("done flag without a phase ending");
  AST_BGOS_NEEDS_BG:
    assert property (bg_offset_out |-> bg_tuning_out)
    else $error("background offset alone");
  AST_SETTINGS_HELD:
    assert property (!cal_reset_out && !$past(cal_reset_out) |->
      $stable(offset_reference_select_spare_out)) else $error("setting moved in pass");
endmodule
bind acc_top acc_top_monitor #(.FG_CYC(FG_CYC)) acc_top_monitor_i (.*);

// file: sim/acc_top_tb.sv
// self-checking bench for the calibration control block
`timescale 1ns/1ns
`include "acc_defs.svh"
`define CHK(nm, e, v) begin num_checks++; if ((v) !== (e)) begin \
  bad_count++; $display("wrong value %s exp %h got %h", nm, e, v); end end
module acc_top_tb;
  logic ref_clk_in, arst_n_in, reg_wr_in, reg_rd_in;
  logic [7:0] reg_addr_in, reg_wdata_in, reg_rdata_out, rd_v, mode, osr;
  logic [3:0] dig_ratio_in, link_ratio_in;
  logic cal_reset_out, cal_clear_out, fg_tuning_out, fg_offset_out;
  logic bg_tuning_out, bg_offset_out, offset_reference_select_spare_out, dig_tick_out;
  logic foreground_complete_flag_out, serial_link_enable_out, link_tick_out;
  int bad_count, num_checks, seed, n_clr, n_fg, n_os, n_dt, n_lt;
  localparam int FG_TB = 4;
  logic [7:0] ra [5] = '{8'h61, 8'h62, 8'h65, 8'h70, 8'h63};
  logic [7:0] rv [5] = '{8'h01, 8'h01, 8'h01, 8'h00, 8'h00};
  acc_top #(.FG_CYC(16'(FG_TB))) acc_top_i (.*);
  initial
  begin
    ref_clk_in = 1'b0;
    forever #4 ref_clk_in = ~ref_clk_in;
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk_in);
    reg_wr_in <= 1'b1;
    reg_addr_in <= a;
    reg_wdata_in <= d;
    @(posedge ref_clk_in);
    reg_wr_in <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge ref_clk_in);
    reg_rd_in <= 1'b1;
    reg_addr_in <= a;
    @(posedge ref_clk_in);
    reg_rd_in <= 1'b0;
    #1 rd_v = reg_rdata_out;
  endtask
  // phase length expected from mode bits
  function automatic int fg_len(input logic [7:0] m, input int b);
    return (m[b] && m[0]) ? FG_TB : 0;
  endfunction
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic run_pass;
    n_clr = 0;
    n_fg = 0;
    n_os = 0;
    wr(`ACC_ADDR_RUN, 8'h01);
    repeat (60)
    begin
      @(posedge ref_clk_in);
      #1;
      n_clr += cal_clear_out;
      n_fg += fg_tuning_out;
      n_os += fg_offset_out;
      if (foreground_complete_flag_out === 1'b1)
        break;
    end
  endtask
  initial
  begin
    repeat (20000) @(posedge ref_clk_in);
    bad_count++;
    give_verdict;
  end
  initial
  begin
    seed = 57792;
    arst_n_in = 1'b0;
    reg_wr_in = 1'b0;
    reg_rd_in = 1'b0;
    reg_addr_in = 8'h00;
    reg_wdata_in = 8'h00;
    dig_ratio_in = 4'($random(seed));
    link_ratio_in = 4'($random(seed));
    repeat (5) @(posedge ref_clk_in);
    arst_n_in <= 1'b1;
    repeat (3) @(posedge ref_clk_in);
    wr(8'h63, 8'h5A);
    for (int k = 0; k < 5; k++)
    begin
      rd(ra[k]);
      `CHK("reset value", rv[k], rd_v)
    end
    repeat (20) @(posedge ref_clk_in);
    #1;
    `CHK("first pass", 3'b100, {foreground_complete_flag_out, bg_tuning_out,
      offset_reference_select_spare_out})
    for (int i = 0; i < 8; i++)
    begin
      mode = (i == 0) ? 8'h00 : (i == 1) ? 8'h0F : 8'($random(seed)) & 8'h0F;
      mode[2] = mode[2] & mode[0];
      mode[3] = mode[3] & mode[1];
      osr = {5'h00, mode[1] & (i[0] | 1'($random(seed))), 2'b01};
      wr(`ACC_ADDR_LINK, 8'h00);
      wr(`ACC_ADDR_RUN, 8'h00);
      repeat (3) @(posedge ref_clk_in);
      #1;
      `CHK("hold", 5'b10000, {cal_reset_out, foreground_complete_flag_out,
        serial_link_enable_out, dig_tick_out, link_tick_out})
      wr(`ACC_ADDR_MODE, mode);
      wr(`ACC_ADDR_OFFSET_REFERENCE_SELECT, osr);
      run_pass;
      `CHK("clear cycles", `ACC_CLEAR_CYC, n_clr)
      `CHK("fg cycles", fg_len(mode, 0), n_fg)
      `CHK("fg offset cycles", fg_len(mode, 2), n_os)
      `CHK("done", 1'b1, foreground_complete_flag_out)
      wr(`ACC_ADDR_LINK, 8'h01);
      wr(`ACC_ADDR_MODE, mode ^ 8'h02);
      rd(`ACC_ADDR_MODE);
      `CHK("mode readback", mode ^ 8'h02, rd_v)
      `CHK("captured", {mode[1], mode[1] & mode[3], osr[2], 1'b1},
        {bg_tuning_out, bg_offset_out, offset_reference_select_spare_out,
        serial_link_enable_out})
      rd(`ACC_ADDR_STAT);
      `CHK("status", {6'h00, mode[1], 1'b1}, rd_v)
      n_dt = 0;
      n_lt = 0;
      repeat ((dig_ratio_in + 1) * (link_ratio_in + 1))
      begin
        @(posedge ref_clk_in);
        #1;
        n_dt += dig_tick_out;
        n_lt += link_tick_out;
      end
      `CHK("dig ticks", link_ratio_in + 1, n_dt)
      `CHK("link ticks", dig_ratio_in + 1, n_lt)
    end
    wr(`ACC_ADDR_RUN, 8'h00);
    rd(`ACC_ADDR_STAT);
    `CHK("sequence error", 8'h04, rd_v)
    wr(`ACC_ADDR_STAT, 8'h04);
    rd(`ACC_ADDR_STAT);
    `CHK("error set wins", 8'h04, rd_v)
    wr(`ACC_ADDR_LINK, 8'h00);
    wr(`ACC_ADDR_STAT, 8'h04);
    rd(`ACC_ADDR_STAT);
    `CHK("error cleared", 8'h00, rd_v)
    give_verdict;
  end
endmodule
